//--- aofc_filter_ctl.sv
`timescale 1ns/1ns
`include "aofc_params.svh"
// Summary of operation
// - Enable bits 4..0 of the high compare register pass channels 16..20 to the comparator.
// - Bits 15..5 of the high compare register read as zero and ignore writes.
// - A three-bit ratio field sets sample count, meaning depends on filter mode.
// - Oversampling codes 000 and 100 sum 4 and 2 samples into a 13-bit 12.1 result.
// - Oversampling codes 001 and 101 sum 16 and 8 samples into a 14-bit 12.2 result.
// - Oversampling codes 010 and 110 sum 64 and 32 samples into a 15-bit 12.3 result.
// - Oversampling codes 011 and 111 sum 256 and 128 samples into a 16-bit result.
// - Averaging mode gives a 12-bit mean of 2 to 256 samples for codes 000 to 111.
// - The filter raises the common interrupt on a ready result only when enabled to.
// - A five-bit select picks inputs 0..20 for the filter, higher codes are reserved.
// - A cleared low compare enable bit keeps channel 0..15 from the comparator.
module aofc_filter_ctl #(
    parameter int ADDR_W = 8
) (
    input  wire logic                CLK,
    input  wire logic                RST_N,
    input  wire logic [ADDR_W-1:0]   AWADDR,
    input  wire logic                AWVALID,
    output wire logic                AWREADY,
    input  wire logic [31:0]         WDATA,
    input  wire logic [3:0]          WSTRB,
    input  wire logic                WVALID,
    output wire logic                WREADY,
    output wire logic [1:0]          BRESP,
    output wire logic                BVALID,
    input  wire logic                BREADY,
    input  wire logic [ADDR_W-1:0]   ARADDR,
    input  wire logic                ARVALID,
    output wire logic                ARREADY,
    output wire logic [31:0]         RDATA,
    output wire logic [1:0]          RRESP,
    output wire logic                RVALID,
    input  wire logic                RREADY,
    input  wire logic                CONV_VALID,
    input  wire aofc_pkg::aofc_chan_t CONV_CHAN,
    input  wire aofc_pkg::aofc_smp_t  CONV_DATA,
    output wire logic                CMP_VALID,
    output wire aofc_pkg::aofc_chan_t CMP_CHAN,
    output wire aofc_pkg::aofc_smp_t  CMP_DATA,
    output wire logic                IRQ
);
    import aofc_pkg::*;

    logic              awready_q;
    logic              wready_q;
    logic              bvalid_q;
    logic [1:0]        bresp_q;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0]       wdata_q;
    logic [3:0]        wstrb_q;
    logic              arready_q;
    logic              rvalid_q;
    logic [1:0]        rresp_q;
    logic [31:0]       rdata_q;
    logic [31:0]       rd_val;
    logic              wr_fire;
    logic              wr_hit;
    logic [2:0]        wr_idx;
    logic              ar_fire;
    logic              rd_res;
    logic              wr_lo;
    logic              wr_hi;
    logic              wr_ctl;
    logic              wr_clr;
    logic              wr_ien;
    logic [20:0]       compare_channel_enables_q;
    logic              filter_enable_q;
    aofc_mode_e        mode_q;
    logic [2:0]        ratio_select_q;
    logic              common_irq_enable_q;
    logic              rdy_q;
    aofc_chan_t        filter_channel_select_q;
    logic [15:0]       ctl_rd;
    logic [15:0]       ctl_wr;
    aofc_fst_e         fst_q;
    logic              flt_ok;
    logic [1:0]        sts_q;
    logic [1:0]        irq_en_q;
    logic [1:0]        evt;
    logic [1:0]        clr_mask;
    logic              irq_q;
    logic              cmp_valid_q;
    aofc_chan_t        cmp_chan_q;
    aofc_smp_t         cmp_data_q;
    logic [8:0]        h_cnt_q;

    aofc_acc_if acc_if ();

    function automatic logic f_hit(logic [ADDR_W-1:0] a);
        f_hit = (a[ADDR_W-1:5] == '0) && (a[4:2] <= `AOFC_IDX_LAST) && (a[1:0] == 2'h0);
    endfunction

    function automatic logic [2:0] f_idx(logic [ADDR_W-1:0] a);
        f_idx = a[4:2];
    endfunction

    function automatic logic [15:0] f_merge(logic [15:0] old, logic [31:0] d, logic [3:0] s);
        f_merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // log2 of sample count per mode
    function automatic logic [3:0] f_log2n(aofc_mode_e m, logic [2:0] r);
        if (m == AOFC_AVG) begin
            f_log2n = {1'b0, r} + 4'h1;
        end else if (r[2]) begin
            f_log2n = {1'b0, r[1:0], 1'b1};
        end else begin
            f_log2n = {1'b0, r[1:0], 1'b0} + 4'h2;
        end
    endfunction

    // keep half the gain, or none
    function automatic logic [3:0] f_shift(aofc_mode_e m, logic [2:0] r);
        logic [3:0] k;
        k = f_log2n(m, r);
        f_shift = (m == AOFC_AVG) ? k : (k >> 1);
    endfunction

    function automatic logic [4:0] f_res_w(aofc_mode_e m, logic [2:0] r);
        logic [3:0] k;
        k = f_log2n(m, r);
        f_res_w = (m == AOFC_AVG) ? `AOFC_SMP_BITS : `AOFC_SMP_BITS + 5'((k + 4'h1) >> 1);
    endfunction

    function automatic logic f_chan_on(aofc_chan_t c, logic [20:0] en);
        f_chan_on = (c <= `AOFC_CH_LAST) ? en[c] : 1'b0;
    endfunction

    assign AWREADY = awready_q;
    assign WREADY  = wready_q;
    assign BVALID  = bvalid_q;
    assign BRESP   = bresp_q;
    assign ARREADY = arready_q;
    assign RVALID  = rvalid_q;
    assign RRESP   = rresp_q;
    assign RDATA   = rdata_q;
    assign CMP_VALID = cmp_valid_q;
    assign CMP_CHAN  = cmp_chan_q;
    assign CMP_DATA  = cmp_data_q;
    assign IRQ       = irq_q;

    assign wr_fire = !awready_q && !wready_q && !bvalid_q;
    assign wr_hit  = f_hit(awaddr_q);
    assign wr_idx  = f_idx(awaddr_q);
    assign wr_lo   = wr_fire && wr_hit && wr_idx == `AOFC_IDX_CMP_LO;
    assign wr_hi   = wr_fire && wr_hit && wr_idx == `AOFC_IDX_CMP_HI;
    assign wr_ctl  = wr_fire && wr_hit && wr_idx == `AOFC_IDX_CTL;
    assign wr_clr  = wr_fire && wr_hit && wr_idx == `AOFC_IDX_CLR;
    assign wr_ien  = wr_fire && wr_hit && wr_idx == `AOFC_IDX_IEN;
    assign ar_fire = ARVALID && arready_q;
    assign rd_res  = ar_fire && f_hit(ARADDR) && f_idx(ARADDR) == `AOFC_IDX_RES;

    // Write address and data may arrive in either order
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            awready_q <= 1'b1;
            wready_q  <= 1'b1;
            bvalid_q  <= 1'b0;
            bresp_q   <= `AOFC_RESP_OK;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
        end else begin
            if (AWVALID && awready_q) begin
                awready_q <= 1'b0;
                awaddr_q  <= AWADDR;
            end
            if (WVALID && wready_q) begin
                wready_q <= 1'b0;
                wdata_q  <= WDATA;
                wstrb_q  <= WSTRB;
            end
            if (wr_fire) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? `AOFC_RESP_OK : `AOFC_RESP_SLVERR;
            end else if (bvalid_q && BREADY) begin
                bvalid_q  <= 1'b0;
                awready_q <= 1'b1;
                wready_q  <= 1'b1;
            end
        end
    end

    always_comb begin
        rd_val = 32'h0;
        case (f_idx(ARADDR))
            `AOFC_IDX_CMP_LO: rd_val = {16'h0, compare_channel_enables_q[15:0]};
            `AOFC_IDX_CMP_HI: rd_val = {27'h0, compare_channel_enables_q[20:16]};
            `AOFC_IDX_CTL:    rd_val = {16'h0, ctl_rd};
            `AOFC_IDX_RES:    rd_val = {16'h0, acc_if.result};
            `AOFC_IDX_STS:    rd_val = {30'h0, sts_q};
            `AOFC_IDX_IEN:    rd_val = {30'h0, irq_en_q};
            default:          rd_val = 32'h0;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            arready_q <= 1'b1;
            rvalid_q  <= 1'b0;
            rresp_q   <= `AOFC_RESP_OK;
            rdata_q   <= 32'h0;
        end else if (ar_fire) begin
            arready_q <= 1'b0;
            rvalid_q  <= 1'b1;
            rresp_q   <= f_hit(ARADDR) ? `AOFC_RESP_OK : `AOFC_RESP_SLVERR;
            rdata_q   <= f_hit(ARADDR) ? rd_val : 32'h0;
        end else if (rvalid_q && RREADY) begin
            rvalid_q  <= 1'b0;
            arready_q <= 1'b1;
        end
    end

    // enable bits, high word keeps five bits
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            compare_channel_enables_q <= `AOFC_RST_CMP;
        end else if (wr_lo) begin
            compare_channel_enables_q[15:0] <=
                f_merge(compare_channel_enables_q[15:0], wdata_q, wstrb_q);
        end else if (wr_hi) begin
            compare_channel_enables_q[20:16] <=
                5'(f_merge({11'h0, compare_channel_enables_q[20:16]}, wdata_q, wstrb_q));
        end
    end

    assign ctl_rd = {filter_enable_q, mode_q, ratio_select_q, common_irq_enable_q, rdy_q,
                     3'h0, filter_channel_select_q};
    assign ctl_wr = f_merge(ctl_rd, wdata_q, wstrb_q);

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            filter_enable_q         <= 1'b0;
            mode_q                  <= AOFC_OS;
            ratio_select_q          <= `AOFC_RST_RATIO;
            common_irq_enable_q     <= 1'b0;
            filter_channel_select_q <= `AOFC_RST_CHAN;
        end else if (wr_ctl) begin
            filter_enable_q         <= ctl_wr[`AOFC_CTL_EN];
            mode_q                  <= aofc_mode_e'(ctl_wr[`AOFC_CTL_MODE]);
            ratio_select_q          <= ctl_wr[`AOFC_CTL_RATIO];
            common_irq_enable_q     <= ctl_wr[`AOFC_CTL_IRQ];
            filter_channel_select_q <= ctl_wr[`AOFC_CTL_CHAN];
        end
    end

    // run only when enabled, mode and channel valid
    assign flt_ok = filter_enable_q && (mode_q == AOFC_OS || mode_q == AOFC_AVG) &&
                    filter_channel_select_q <= `AOFC_CH_LAST;

    // Any control write restarts the running block
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            fst_q <= FST_IDLE;
        end else begin
            case (fst_q)
                FST_IDLE: begin
                    if (flt_ok && !wr_ctl) begin
                        fst_q <= FST_ACC;
                    end
                end
                FST_ACC: begin
                    if (!flt_ok || wr_ctl) begin
                        fst_q <= FST_IDLE;
                    end
                end
                default: fst_q <= FST_IDLE;
            endcase
        end
    end

    // only the selected input feeds the filter
    assign acc_if.clr   = fst_q == FST_IDLE;
    assign acc_if.vld   = fst_q == FST_ACC && CONV_VALID && !wr_ctl &&
                          CONV_CHAN == filter_channel_select_q;
    assign acc_if.smp   = CONV_DATA;
    assign acc_if.log2n = f_log2n(mode_q, ratio_select_q);
    assign acc_if.shift = f_shift(mode_q, ratio_select_q);

    aofc_accum u_accum (
        .CLK   (CLK),
        .RST_N (RST_N),
        .bus   (acc_if.acc)
    );

    // set beats read clear, disable forces low
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rdy_q <= 1'b0;
        end else if (!filter_enable_q) begin
            rdy_q <= 1'b0;
        end else if (acc_if.done) begin
            rdy_q <= 1'b1;
        end else if (rd_res) begin
            rdy_q <= 1'b0;
        end
    end

    // result event only with common enable
    assign evt[0]   = acc_if.done && filter_enable_q && common_irq_enable_q;
    assign evt[1]   = acc_if.done && filter_enable_q && rdy_q && !rd_res;
    assign clr_mask = wr_clr ? (wdata_q[1:0] & {2{wstrb_q[0]}}) : 2'h0;

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            sts_q <= `AOFC_RST_EVT;
        end else begin
            sts_q <= (sts_q & ~clr_mask) | evt;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            irq_en_q <= `AOFC_RST_EVT;
        end else if (wr_ien && wstrb_q[0]) begin
            irq_en_q <= wdata_q[1:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(sts_q & irq_en_q);
        end
    end

    // only enabled channels reach the comparator
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cmp_valid_q <= 1'b0;
            cmp_chan_q  <= '0;
            cmp_data_q  <= '0;
        end else begin
            cmp_valid_q <= CONV_VALID && f_chan_on(CONV_CHAN, compare_channel_enables_q);
            cmp_chan_q  <= CONV_CHAN;
            cmp_data_q  <= CONV_DATA;
        end
    end

    // Sample tally seen by the checks
    always_ff @(posedge CLK) begin
        if (!RST_N || acc_if.clr) begin
            h_cnt_q <= 9'h000;
        end else if (acc_if.done) begin
            h_cnt_q <= acc_if.vld ? 9'h001 : 9'h000;
        end else if (acc_if.vld) begin
            h_cnt_q <= h_cnt_q + 9'h001;
        end
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RST_N);

    chk_high_resv: assert property (
        (ar_fire && f_hit(ARADDR) && f_idx(ARADDR) == `AOFC_IDX_CMP_HI) |=> RDATA[31:5] == 27'h0
    ) else $error("high compare register reserved bits not zero");

    chk_high_gate: assert property (
        (CONV_VALID && CONV_CHAN >= `AOFC_CH_HI_BASE && CONV_CHAN <= `AOFC_CH_LAST &&
         !compare_channel_enables_q[CONV_CHAN]) |=> !CMP_VALID
    ) else $error("disabled high channel reached comparator");

    chk_pass_on: assert property (
        (CONV_VALID && f_chan_on(CONV_CHAN, compare_channel_enables_q))
        |=> CMP_VALID && CMP_CHAN == $past(CONV_CHAN) && CMP_DATA == $past(CONV_DATA)
    ) else $error("enabled channel not passed to comparator");

    chk_low_gate: assert property (
        (CONV_VALID && CONV_CHAN < `AOFC_CH_HI_BASE && !compare_channel_enables_q[CONV_CHAN])
        |=> !CMP_VALID
    ) else $error("disabled low channel reached comparator");

    chk_ratio_count: assert property (
        acc_if.done |-> h_cnt_q == (9'h001 << f_log2n(mode_q, ratio_select_q))
    ) else $error("filter block size does not match ratio");

    chk_os_width: assert property (
        (acc_if.done && mode_q == AOFC_OS)
        |=> (acc_if.result >> f_res_w(mode_q, ratio_select_q)) == 16'h0
    ) else $error("oversampled result wider than its format");

    chk_avg_width: assert property (
        (acc_if.done && mode_q == AOFC_AVG) |=> acc_if.result[15:12] == 4'h0
    ) else $error("averaged result wider than twelve bits");

    chk_irq_set: assert property (
        (acc_if.done && filter_enable_q && common_irq_enable_q) |=> sts_q[0] ##1 (IRQ || !irq_en_q[0])
    ) else $error("ready result did not flag the interrupt");

    chk_irq_quiet: assert property (
        (!sts_q[0] && !common_irq_enable_q) |=> !sts_q[0]
    ) else $error("filter flagged interrupt while disabled");

    chk_chan_resv: assert property (
        (filter_channel_select_q > `AOFC_CH_LAST || mode_q == AOFC_RSV1 || mode_q == AOFC_RSV2)
        |-> fst_q == FST_IDLE
    ) else $error("filter ran on a reserved channel or mode");

    chk_off_clear: assert property (
        !filter_enable_q |=> !rdy_q && !acc_if.done
    ) else $error("ready flag or result while filter off");

    chk_rdy_set: assert property (
        (acc_if.done && filter_enable_q) |=> rdy_q
    ) else $error("stored result did not set ready");

    chk_rd_clear: assert property (
        (rd_res && !acc_if.done && filter_enable_q) |=> !rdy_q
    ) else $error("result read did not clear ready");

    cov_avg_done: cover property (acc_if.done && mode_q == AOFC_AVG);
    cov_os_256: cover property (acc_if.done && mode_q == AOFC_OS && ratio_select_q == 3'h3);
    cov_irq_rise: cover property ($rose(irq_q));
    cov_slverr: cover property (bvalid_q && bresp_q == `AOFC_RESP_SLVERR);
endmodule

//--- aofc_params.svh
`ifndef AOFC_PARAMS_SVH
`define AOFC_PARAMS_SVH

// Register word indexes, byte address is four times the index
`define AOFC_IDX_CMP_LO  3'h0
`define AOFC_IDX_CMP_HI  3'h1
`define AOFC_IDX_CTL     3'h2
`define AOFC_IDX_RES     3'h3
`define AOFC_IDX_STS     3'h4
`define AOFC_IDX_CLR     3'h5
`define AOFC_IDX_IEN     3'h6
`define AOFC_IDX_LAST    3'h6

// Filter control fields
`define AOFC_CTL_EN      15
`define AOFC_CTL_MODE    14:13
`define AOFC_CTL_RATIO   12:10
`define AOFC_CTL_IRQ     9
`define AOFC_CTL_CHAN    4:0

// Channel map
`define AOFC_CH_HI_BASE  5'h10
`define AOFC_CH_LAST     5'h14

// Reset values
`define AOFC_RST_CMP     21'h000000
`define AOFC_RST_CHAN    5'h00
`define AOFC_RST_RATIO   3'h0
`define AOFC_RST_EVT     2'h0

// Result format
`define AOFC_SMP_BITS    5'h0c

// Bus answers
`define AOFC_RESP_OK     2'h0
`define AOFC_RESP_SLVERR 2'h2

`endif

//--- aofc_pkg.sv
package aofc_pkg;
    typedef logic [4:0]  aofc_chan_t;
    typedef logic [11:0] aofc_smp_t;
    typedef logic [15:0] aofc_res_t;

    typedef enum logic [1:0] {
        AOFC_OS   = 2'b00,
        AOFC_RSV1 = 2'b01,
        AOFC_RSV2 = 2'b10,
        AOFC_AVG  = 2'b11
    } aofc_mode_e;

    typedef enum logic {
        FST_IDLE = 1'b0,
        FST_ACC  = 1'b1
    } aofc_fst_e;
endpackage

//--- aofc_acc_if.sv
`timescale 1ns/1ns
interface aofc_acc_if;
    import aofc_pkg::*;
    logic       clr;
    logic       vld;
    aofc_smp_t  smp;
    logic [3:0] log2n;
    logic [3:0] shift;
    logic       done;
    aofc_res_t  result;

    modport ctl (output clr, vld, smp, log2n, shift, input done, result);
    modport acc (input clr, vld, smp, log2n, shift, output done, result);
endinterface

//--- aofc_accum.sv
`timescale 1ns/1ns
module aofc_accum #(
    parameter int SUM_W = 20,
    parameter int CNT_W = 9
) (
    input wire logic CLK,
    input wire logic RST_N,
    aofc_acc_if.acc  bus
);
    import aofc_pkg::*;

    logic [SUM_W-1:0] sum_q;
    logic [SUM_W-1:0] sum_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic             last;
    logic             fin;

    assign sum_d = sum_q + SUM_W'(bus.smp);
    assign cnt_d = cnt_q + CNT_W'(1);
    assign last  = cnt_d == (CNT_W'(1) << bus.log2n);
    assign fin   = bus.vld && last && !bus.clr;

    // Running sum restarts after each finished block
    always_ff @(posedge CLK) begin
        if (!RST_N || bus.clr) begin
            sum_q <= '0;
            cnt_q <= '0;
        end else if (bus.vld) begin
            sum_q <= last ? '0 : sum_d;
            cnt_q <= last ? '0 : cnt_d;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            bus.done   <= 1'b0;
            bus.result <= '0;
        end else begin
            bus.done <= fin;
            if (fin) begin
                bus.result <= 16'(sum_d >> bus.shift);
            end
        end
    end
endmodule

//--- aofc_conv_src.sv
`timescale 1ns/1ns
module aofc_conv_src (
    input  wire logic            clk,
    output logic                 conv_valid,
    output aofc_pkg::aofc_chan_t conv_chan,
    output aofc_pkg::aofc_smp_t  conv_data
);
    import aofc_pkg::*;
    aofc_chan_t ch_q;
    aofc_smp_t  smp_q;
    // Idle lines show inverted last value, never a stale sample
    assign conv_chan = conv_valid ? ch_q : ~ch_q;
    assign conv_data = conv_valid ? smp_q : ~smp_q;
    initial begin
        conv_valid = 1'b0;
        ch_q       = 5'h00;
        smp_q      = 12'h000;
    end
    // Odd samples carry one count more, so truncation shows in results
    task automatic send(input aofc_chan_t ch, input aofc_smp_t d, input int n, input int gap);
        for (int i = 0; i < n; i++) begin
            conv_valid <= 1'b1;
            ch_q <= ch;
            smp_q <= d + aofc_smp_t'(i & 1);
            @(posedge clk);
            if (gap > 0) begin
                conv_valid <= 1'b0;
                repeat (gap) @(posedge clk);
            end
        end
        conv_valid <= 1'b0;
    endtask
endmodule

//--- adc_oversampling_filter_ctl_tb.sv
`timescale 1ns/1ns
`include "aofc_params.svh"
module adc_oversampling_filter_ctl_tb;
    import aofc_pkg::*;
    logic             clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
    logic [7:0]       awaddr, araddr;
    logic [31:0]      wdata;
    wire logic        awready, wready, bvalid, arready, rvalid, cmp_valid, irq, conv_valid;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    wire aofc_chan_t  cmp_chan, conv_chan;
    wire aofc_smp_t   cmp_data, conv_data;
    int               num_errors = 0;
    int               n_tests = 0;
    int               cmp_cnt = 0;
    logic [16:0]      cmp_seen = 17'h00000;
    aofc_chan_t       ch_tab[4] = '{5'h10, 5'h11, 5'h03, 5'h04};
    logic [15:0]      neg_tab[3] = '{16'h6205, 16'ha205, 16'he215};

    aofc_filter_ctl uut (.CLK(clk), .RST_N(rst_n), .AWADDR(awaddr), .AWVALID(awvalid),
        .AWREADY(awready), .WDATA(wdata), .WSTRB(4'hf), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr),
        .ARVALID(arvalid), .ARREADY(arready), .RDATA(rdata), .RRESP(rresp),
        .RVALID(rvalid), .RREADY(rready), .CONV_VALID(conv_valid), .CONV_CHAN(conv_chan),
        .CONV_DATA(conv_data), .CMP_VALID(cmp_valid), .CMP_CHAN(cmp_chan),
        .CMP_DATA(cmp_data), .IRQ(irq));
    aofc_conv_src src (.clk(clk), .conv_valid(conv_valid), .conv_chan(conv_chan),
        .conv_data(conv_data));

    initial clk = 1'b0;
    always #4 clk = ~clk;
    always @(posedge clk) begin
        if (cmp_valid === 1'b1) begin
            cmp_cnt++;
            cmp_seen <= {cmp_chan, cmp_data};
        end
    end

    function automatic logic [7:0] ra(input logic [2:0] i);
        return {3'h0, i, 2'b00};
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] resp);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        resp = bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        resp = rresp;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp,
                        input string what);
        logic [31:0] d;
        logic [1:0]  r;
        rd(a, d, r);
        chk(what, exp, d & mask);
    endtask
    task automatic report_and_stop;
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        num_errors++;
        report_and_stop();
    end

    initial begin
        logic [31:0] d, sum;
        logic [1:0]  r, m;
        logic [2:0]  rs;
        int          n, lg;
        rst_n = 1'b0;
        // Response channels always accepted, so back-to-back calls never toggle them
        {awvalid, wvalid, bready, arvalid, rready} = 5'h05;
        {awaddr, araddr, wdata} = 48'h0;
        cyc(3);
        rst_n <= 1'b1;
        cyc(1);
        rchk(ra(`AOFC_IDX_CMP_HI), 32'hffffffff, 32'h0, "cmp_hi_reset");
        rchk(ra(`AOFC_IDX_CTL), 32'hffffffff, 32'h0, "ctl_reset");
        wr(ra(`AOFC_IDX_CMP_HI), 32'hffffffff, r);
        rchk(ra(`AOFC_IDX_CMP_HI), 32'hffffffff, 32'h1f, "cmp_hi_mask");
        wr(ra(`AOFC_IDX_CMP_HI), 32'h1, r);
        wr(ra(`AOFC_IDX_CMP_LO), 32'h8, r);
        for (int i = 0; i < 4; i++) begin
            n = cmp_cnt;
            src.send(ch_tab[i], 12'h123, 1, 0);
            cyc(2);
            chk("cmp_pass", {31'h0, ~i[0]}, 32'(cmp_cnt - n));
            if (!i[0]) chk("cmp_word", {15'h0, ch_tab[i], 12'h123}, {15'h0, cmp_seen});
        end
        wr(ra(`AOFC_IDX_IEN), 32'h1, r);
        // Every ratio code in both modes; irq enable toggles with the code
        for (int k = 0; k < 16; k++) begin
            m = k[3] ? 2'b11 : 2'b00;
            rs = k[2:0];
            n = m[0] ? (2 << rs) : ((rs[2] ? 2 : 4) << (2 * rs[1:0]));
            lg = $clog2(n);
            sum = n * 32'habc + n / 2;
            wr(ra(`AOFC_IDX_CTL), {16'h0, 1'b1, m, rs, rs[0], 4'h0, 5'h05}, r);
            cyc(2);
            src.send(5'h06, 12'hfff, 1, 0);
            cyc(1);
            src.send(5'h05, 12'habc, n, k % 2);
            cyc(4);
            chk("irq_ready", {31'h0, rs[0]}, {31'h0, irq});
            rchk(ra(`AOFC_IDX_CTL), 32'h100, 32'h100, "ready_set");
            rchk(ra(`AOFC_IDX_RES), 32'hffffffff, m[0] ? sum >> lg : sum >> (lg / 2),
                 "result");
            rchk(ra(`AOFC_IDX_CTL), 32'h100, 32'h0, "ready_clear");
            wr(ra(`AOFC_IDX_CLR), 32'h3, r);
            cyc(2);
            chk("irq_clear", 32'h0, {31'h0, irq});
        end
        // Filter off, reserved mode, reserved channel: nothing completes
        for (int k = 0; k < 3; k++) begin
            wr(ra(`AOFC_IDX_CTL), {16'h0, neg_tab[k]}, r);
            cyc(2);
            src.send(neg_tab[k][4:0], 12'habc, 4, 0);
            cyc(4);
            rchk(ra(`AOFC_IDX_CTL), 32'h100, 32'h0, "ready_idle");
            chk("irq_idle", 32'h0, {31'h0, irq});
        end
        rd(8'h1c, d, r);
        chk("unmapped_rd", {30'h0, `AOFC_RESP_SLVERR}, {30'h0, r});
        wr(8'h1c, 32'h1, r);
        chk("unmapped_wr", {30'h0, `AOFC_RESP_SLVERR}, {30'h0, r});
        report_and_stop();
    end
endmodule
